//--- hdl/pphn_host.sv
// Host end of a 25-pin parallel printer port: forward byte transfers
// with strobe handshake, reverse transfers four bits at a time.
// Assumes pin inputs already synchronous to clk and a user side that
// holds tx_valid until tx_taken pulses.
//
// Contract
// RULE1: Strobe pulses low per forward byte; it stays high in reverse.
// RULE2: Host drives eight data lines, bit 0 lowest; released in reverse.
// RULE3: Peripheral pulls acknowledge low when it has taken a forward byte.
// RULE4: In reverse, acknowledge low marks the status nibble as valid.
// RULE5: Peripheral holds busy high while it cannot take a forward byte.
// RULE6: Reverse nibble: busy bit3/7, paper bit2/6, online bit1/5, fault 0/4.
// RULE7: Peripheral drives paper fault high for a paper path problem.
// RULE8: Peripheral reports on line through the online line.
// RULE9: Host drives auto line feed low to request automatic line feed.
// RULE10: Reverse: auto feed low means ready, high acknowledges the nibble.
// RULE11: Fault low is an error forward and data ready in reverse.
// RULE12: Host resets the peripheral by driving initialize low.
// RULE13: Select-in low selects forward; high sets reverse direction.
// RULE14: No new strobe while busy is high or before the last acknowledge.
// RULE15: Two reverse nibbles form one byte, lower nibble first.
`timescale 1ns/1ps

module pphn_host (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // User control
  input wire logic rev_mode,
  input wire logic auto_feed_en,
  input wire logic init_req,
  // Forward byte stream
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_taken,
  output logic fwd_busy,
  // Reverse byte stream
  output logic rx_valid,
  output logic [7:0] rx_data,
  // Forward peripheral status
  output pphn_pkg::pphn_status_t status,
  // Port lines
  input wire pphn_pkg::pphn_pins_in_t pins_in,
  output pphn_pkg::pphn_pins_out_t pins_out
);
  import pphn_pkg::*;

  pphn_state_t st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  pphn_pins_out_t pins_q, pins_d;
  pphn_status_t status_q, status_d;
  logic dir_rev_q, dir_rev_d;
  logic nib_hi_q, nib_hi_d;
  logic [3:0] lo_nib_q, lo_nib_d;
  logic [7:0] rx_data_q, rx_data_d;
  logic rx_valid_q, rx_valid_d;
  logic tx_taken_q, tx_taken_d;
  logic fwd_busy_q, fwd_busy_d;

  // Decoded conditions
  wire logic cnt_done;
  wire logic fwd_free;
  wire logic fwd_start;
  wire logic dir_change;
  wire logic rev_data_ready;
  wire logic nib_valid;
  logic [3:0] nibble;

  assign cnt_done = (cnt_q == '0);
  // Peripheral free and previous acknowledge released
  assign fwd_free = !pins_in.busy && pins_in.ack_n; // [RULE5] [RULE14]
  assign dir_change = (dir_rev_q != rev_mode);
  assign fwd_start = !dir_change && !dir_rev_q && tx_valid && fwd_free;
  assign rev_data_ready = !dir_change && dir_rev_q
                          && !pins_in.fault_n; // [RULE11]
  assign nib_valid = !pins_in.ack_n; // [RULE4]

  // Status lines carry one nibble in reverse
  always_comb begin
    nibble = '0;
    nibble[NIB_BUSY_POS] = pins_in.busy; // [RULE6]
    nibble[NIB_PAPER_POS] = pins_in.paper_fault; // [RULE6]
    nibble[NIB_ONLINE_POS] = pins_in.online; // [RULE6]
    nibble[NIB_FAULT_POS] = pins_in.fault_n; // [RULE6]
  end

  // Transfer sequencer
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_done ? cnt_q : cnt_q - CNT_W'(1);
    dir_rev_d = dir_rev_q;
    nib_hi_d = nib_hi_q;
    lo_nib_d = lo_nib_q;
    rx_data_d = rx_data_q;
    rx_valid_d = 1'b0;
    tx_taken_d = 1'b0;
    pins_d = pins_q;
    unique case (st_q)
      PPHN_IDLE: begin
        if (dir_change) begin
          // Direction only turns between whole bytes
          dir_rev_d = rev_mode;
          nib_hi_d = 1'b0;
        end else if (rev_data_ready) begin
          st_d = PPHN_R_REQ;
        end else if (fwd_start) begin
          pins_d.data = tx_data; // [RULE2]
          tx_taken_d = 1'b1;
          cnt_d = SETUP_CYC;
          st_d = PPHN_F_SETUP;
        end
      end
      PPHN_F_SETUP: begin
        if (cnt_done) begin
          cnt_d = STROBE_CYC;
          st_d = PPHN_F_STROBE;
        end
      end
      PPHN_F_STROBE: begin
        if (cnt_done) begin
          st_d = PPHN_F_ACK_WAIT;
        end
      end
      PPHN_F_ACK_WAIT: begin
        if (!pins_in.ack_n) begin // [RULE3]
          st_d = PPHN_F_RELEASE;
        end
      end
      PPHN_F_RELEASE: begin
        if (pins_in.ack_n) begin // [RULE14]
          st_d = PPHN_IDLE;
        end
      end
      PPHN_R_REQ: begin
        if (nib_valid) begin
          nib_hi_d = !nib_hi_q;
          if (!nib_hi_q) begin
            lo_nib_d = nibble; // [RULE15]
          end else begin
            rx_data_d = {nibble, lo_nib_q}; // [RULE15]
            rx_valid_d = 1'b1;
          end
          st_d = PPHN_R_RELEASE;
        end
      end
      PPHN_R_RELEASE: begin
        // Wait for the peripheral to end its nibble strobe
        if (pins_in.ack_n) begin
          st_d = nib_hi_q ? PPHN_R_REQ : PPHN_IDLE;
        end
      end
      default: begin
        st_d = PPHN_IDLE;
      end
    endcase

    // Line levels follow the next state so each pin is a flop
    pins_d.strobe_n = !(st_d == PPHN_F_STROBE); // [RULE1]
    pins_d.data_oe = !dir_rev_d; // [RULE2]
    pins_d.select_in_n = dir_rev_d; // [RULE13]
    pins_d.init_n = !init_req; // [RULE12]
    if (dir_rev_d) begin
      pins_d.auto_line_feed_n = !(st_d == PPHN_R_REQ); // [RULE10]
    end else begin
      pins_d.auto_line_feed_n = !auto_feed_en; // [RULE9]
    end
  end

  // Forward status shown only while the lines carry status
  always_comb begin
    status_d = status_q;
    if (!dir_rev_q) begin
      status_d.paper_fault = pins_in.paper_fault; // [RULE7]
      status_d.online = pins_in.online; // [RULE8]
      status_d.error = !pins_in.fault_n; // [RULE11]
    end
  end

  assign fwd_busy_d = (st_d != PPHN_IDLE) || dir_rev_d;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= PPHN_IDLE;
      cnt_q <= '0;
      pins_q <= PINS_RST;
      status_q <= STATUS_RST;
      dir_rev_q <= 1'b0;
      nib_hi_q <= 1'b0;
      lo_nib_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      pins_q <= pins_d;
      status_q <= status_d;
      dir_rev_q <= dir_rev_d;
      nib_hi_q <= nib_hi_d;
      lo_nib_q <= lo_nib_d;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_data_q <= '0;
      rx_valid_q <= 1'b0;
      tx_taken_q <= 1'b0;
      fwd_busy_q <= 1'b0;
    end else begin
      rx_data_q <= rx_data_d;
      rx_valid_q <= rx_valid_d;
      tx_taken_q <= tx_taken_d;
      fwd_busy_q <= fwd_busy_d;
    end
  end

  assign pins_out = pins_q;
  assign status = status_q;
  assign rx_data = rx_data_q;
  assign rx_valid = rx_valid_q;
  assign tx_taken = tx_taken_q;
  assign fwd_busy = fwd_busy_q;

endmodule

//--- shared/pphn_pkg.sv
// Package for the parallel port host with nibble-mode reverse transfers.
// Assumes one 40 MHz system clock; pin levels are synchronous to it.
package pphn_pkg;

  // Clock and pin timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int T_SETUP_NS = 500;
  localparam int T_STROBE_NS = 1000;

  // Least time in ns to whole clock cycles, never below one
  function automatic int pphn_cyc_min(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] SETUP_CYC = CNT_W'(pphn_cyc_min(T_SETUP_NS));
  localparam logic [CNT_W-1:0] STROBE_CYC = CNT_W'(pphn_cyc_min(T_STROBE_NS));

  // Status line positions inside a returned nibble
  localparam int NIB_FAULT_POS = 0;
  localparam int NIB_ONLINE_POS = 1;
  localparam int NIB_PAPER_POS = 2;
  localparam int NIB_BUSY_POS = 3;

  // Lines driven by the host
  typedef struct packed {
    logic strobe_n;
    logic [7:0] data;
    logic data_oe;
    logic auto_line_feed_n;
    logic init_n;
    logic select_in_n;
  } pphn_pins_out_t;

  // Lines driven by the peripheral
  typedef struct packed {
    logic ack_n;
    logic busy;
    logic paper_fault;
    logic online;
    logic fault_n;
  } pphn_pins_in_t;

  // Forward-direction peripheral status
  typedef struct packed {
    logic paper_fault;
    logic online;
    logic error;
  } pphn_status_t;

  localparam pphn_pins_out_t PINS_RST = '{
    strobe_n: 1'b1,
    data: 8'h00,
    data_oe: 1'b1,
    auto_line_feed_n: 1'b1,
    init_n: 1'b0,
    select_in_n: 1'b0
  };

  localparam pphn_status_t STATUS_RST = '{
    paper_fault: 1'b0,
    online: 1'b0,
    error: 1'b0
  };

  typedef enum logic [2:0] {
    PPHN_IDLE,
    PPHN_F_SETUP,
    PPHN_F_STROBE,
    PPHN_F_ACK_WAIT,
    PPHN_F_RELEASE,
    PPHN_R_REQ,
    PPHN_R_RELEASE
  } pphn_state_t;

endpackage

//--- verification/pphn_host_sva.sv
// Checker for the parallel port host, bound to its ports.
// Assumes pin inputs synchronous to clk.
`timescale 1ns/1ps
module pphn_host_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // User side
  input wire logic auto_feed_en,
  input wire logic init_req,
  input wire logic tx_valid,
  input wire logic tx_taken,
  input wire logic fwd_busy,
  input wire logic rx_valid,
  // Port lines
  input wire pphn_pkg::pphn_pins_in_t pins_in,
  input wire pphn_pkg::pphn_pins_out_t pins_out
);
  import pphn_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_strobe_rev_high: assert property (pins_out.select_in_n |->
    pins_out.strobe_n) else $error("strobe low in reverse");
  a_strobe_width: assert property ($fell(pins_out.strobe_n) |->
    ##40 !pins_out.strobe_n ##1 pins_out.strobe_n)
    else $error("strobe width wrong");
  a_setup_time: assert property (tx_taken |->
    ##[20:22] $fell(pins_out.strobe_n)) else $error("setup wrong");
  a_data_hold: assert property (!pins_out.strobe_n |->
    $stable(pins_out.data)) else $error("data moved in strobe");
  a_oe_dir: assert property (pins_out.data_oe ==
    !pins_out.select_in_n) else $error("data enable wrong");
  a_take_ok: assert property (tx_taken |-> $past(tx_valid) &&
    !$past(pins_in.busy) && $past(pins_in.ack_n))
    else $error("byte taken while not ready");
  a_take_pulse: assert property (tx_taken |=> !tx_taken && fwd_busy)
    else $error("taken pulse wrong");
  a_init_follow: assert property (arst_n |=>
    pins_out.init_n == !$past(init_req)) else $error("init wrong");
  a_alf_fwd: assert property (!pins_out.select_in_n &&
    !$past(pins_out.select_in_n) |->
    pins_out.auto_line_feed_n == !$past(auto_feed_en))
    else $error("auto feed wrong");
  a_rev_alf_ack: assert property (pins_out.select_in_n &&
    !pins_out.auto_line_feed_n && !pins_in.ack_n |=>
    pins_out.auto_line_feed_n) else $error("nibble not acked");
  a_rx_source: assert property (rx_valid |->
    pins_out.select_in_n && !$past(pins_in.ack_n))
    else $error("rx byte without ack");
endmodule
bind pphn_host pphn_host_sva i_pphn_host_sva (.clk, .arst_n,
  .auto_feed_en, .init_req, .tx_valid, .tx_taken, .fwd_busy,
  .rx_valid, .pins_in, .pins_out);

//--- verification/pphn_host_test.sv
// Self-checking bench for the parallel port host.
// Uses the behavioural printer model on the port side.
`timescale 1ns/1ps
module pphn_host_test;
  import pphn_pkg::*;
  logic clk = 0, arst_n = 0, rev_mode = 0, auto_feed_en = 0;
  logic init_req = 0, tx_valid = 0, rgo = 0;
  logic [7:0] tx_data = 8'h00, rbyte = 8'h00, got, rx_data;
  logic [2:0] st = 3'h3;
  logic tx_taken, fwd_busy, rx_valid;
  pphn_status_t status;
  pphn_pins_in_t pins_in;
  pphn_pins_out_t pins_out;
  int failures = 0, compares = 0, cyc = 0;
  always #12.5 clk = ~clk;
  pphn_host i_pphn_host (.clk, .arst_n, .rev_mode, .auto_feed_en,
    .init_req, .tx_valid, .tx_data, .tx_taken, .fwd_busy, .rx_valid,
    .rx_data, .status, .pins_in, .pins_out);
  pphn_periph i_pphn_periph (.clk, .po(pins_out), .rbyte, .rgo, .st,
    .pi(pins_in), .got);
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      complete_run;
    end
  end
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic t_ctrl(logic v);
    @(posedge clk) init_req <= v;
    auto_feed_en <= v;
    tick(2);
    chk("init_n", 16'(pins_out.init_n), 16'(!v));
    chk("alf_n", 16'(pins_out.auto_line_feed_n), 16'(!v));
  endtask
  task automatic t_fwd(logic [7:0] b);
    int n = 0;
    @(posedge clk) tx_data <= b;
    tx_valid <= 1'b1;
    do tick(1); while (tx_taken !== 1'b1 && ++n < 100);
    chk("tx_taken", 16'(tx_taken), 16'h0001);
    @(posedge clk) tx_valid <= 1'b0;
    n = 0;
    do tick(1); while (fwd_busy !== 1'b0 && ++n < 300);
    chk("fwd_busy", 16'(fwd_busy), 16'h0000);
    chk("got", 16'(got), 16'(b));
  endtask
  task automatic t_status;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk) st <= 3'(i);
      tick(3);
      chk("stat", 16'(status), 16'({i[2:1], ~i[0]}));
    end
    @(posedge clk) st <= 3'h3;
  endtask
  task automatic t_dir(logic r);
    @(posedge clk) rev_mode <= r;
    tick(4);
    chk("select_in_n", 16'(pins_out.select_in_n), 16'(r));
    chk("data_oe", 16'(pins_out.data_oe), 16'(!r));
    chk("strobe_n", 16'(pins_out.strobe_n), 16'h0001);
  endtask
  task automatic t_rev(logic [7:0] b);
    int n = 0;
    @(posedge clk) rbyte <= b;
    rgo <= 1'b1;
    do tick(1); while (rx_valid !== 1'b1 && ++n < 200);
    chk("rx_valid", 16'(rx_valid), 16'h0001);
    chk("rx_data", 16'(rx_data), 16'(b));
    @(posedge clk) rgo <= 1'b0;
    tick(8);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    chk("pins_out", 16'(pins_out), 16'(PINS_RST));
    chk("outs", 16'({tx_taken, rx_valid, fwd_busy}), 16'h0000);
    chk("rx_out", 16'({status, rx_data}), 16'h0000);
    arst_n <= 1'b1;
    t_ctrl(1'b1);
    t_ctrl(1'b0);
    t_fwd(8'h01);
    t_fwd(8'h80);
    t_status;
    t_dir(1'b1);
    t_rev(8'ha5);
    t_rev(8'h3c);
    t_dir(1'b0);
    t_fwd(8'h5a);
    complete_run;
  end
endmodule

//--- verification/pphn_periph.sv
// Behavioural printer on the far side of the port.
// Changes its lines on the falling clock edge.
`timescale 1ns/1ps
module pphn_periph (
  // Clock
  input wire logic clk,
  // Host lines
  input wire pphn_pkg::pphn_pins_out_t po,
  // Bench control
  input wire logic [7:0] rbyte,
  input wire logic rgo,
  input wire logic [2:0] st,
  // Peripheral lines and last byte
  output pphn_pkg::pphn_pins_in_t pi,
  output logic [7:0] got
);
  import pphn_pkg::*;
  initial pi = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
  initial got = 8'h00;
  always begin
    @(negedge clk);
    if (!po.select_in_n && !po.strobe_n) begin
      got <= po.data;
      pi.busy <= 1'b1;
      while (!po.strobe_n) @(negedge clk);
      pi.ack_n <= 1'b0;
      repeat (2) @(negedge clk);
      pi.ack_n <= 1'b1;
      pi.busy <= 1'b0;
    end else if (po.select_in_n && rgo) begin
      pi.fault_n <= 1'b0;
      for (int i = 0; i < 2; i++) begin
        while (po.auto_line_feed_n) @(negedge clk);
        {pi.busy, pi.paper_fault, pi.online, pi.fault_n} <=
          rbyte[4*i+:4];
        @(negedge clk);
        pi.ack_n <= 1'b0;
        while (!po.auto_line_feed_n) @(negedge clk);
        pi.ack_n <= 1'b1;
      end
      pi.busy <= 1'b0;
      pi.fault_n <= 1'b1;
    end else begin
      {pi.paper_fault, pi.online, pi.fault_n} <= st;
    end
  end
endmodule
